//--- shared/timer_pkg.sv
// Package with register map, field positions and bus carrier types for the basic timer
// ****************************************************************************
// Overview of operation
// - Three-bit trigger source select sits in bits 6 to 4 of trigger control.
// - Select 000 pulses the trigger output only on the counter reset made by software update, not on overflow wrap.
// - Select 001 pulses the trigger output when the counter run bit is set.
// - Select 010 pulses the trigger output on every update event.
// - Update DMA request only fires while enable bit 8 is one.
// - Update interrupt drives only while enable bit 0 is one.
// - Update flag sets on update events, except software ones under source select one, cleared by writing zero, one ignored.
// - Writing one to software update generate makes an update, self-clearing.
// - Software update clears main counter and prescaler counter together.
// - Counter register reads live value; writes replace it at once.
// - Counter clock is the input clock divided by divide value plus one.
// - Divide value takes effect only when copied to shadow at update.
// - Sixteen-bit reload limit sets where the up counter wraps.
// - Registers accept half-word and word accesses; reserved bits stay reset, except in run control, which keeps all 16 written bits.
// - Counter counts zero to limit, wraps to zero, updating at overflow.
// - Update suppress blocks update events; software request still clears counters.
// - Update source select one limits interrupt and DMA to overflow only.
// - One-shot mode clears counter run at the next update event.
// ****************************************************************************
`default_nettype none
package timer_pkg;

  // ****************************************************************************
  // Register offsets
  // ****************************************************************************
  localparam logic [7:0] run_control_off    = 8'h00;
  localparam logic [7:0] trigger_out_off    = 8'h04;
  localparam logic [7:0] request_enable_off = 8'h0C;
  localparam logic [7:0] flag_status_off    = 8'h10;
  localparam logic [7:0] event_request_off  = 8'h14;
  localparam logic [7:0] count_value_off    = 8'h24;
  localparam logic [7:0] divide_value_off   = 8'h28;
  localparam logic [7:0] reload_limit_off   = 8'h2C;

  // ****************************************************************************
  // Field positions and widths
  // ****************************************************************************
  localparam int run_bit       = 0;
  localparam int suppress_bit  = 1;
  localparam int source_bit    = 2;
  localparam int one_shot_bit  = 3;
  localparam int trig_lsb      = 4;
  localparam int trig_msb      = 6;
  localparam int irq_en_bit    = 0;
  localparam int dma_en_bit    = 8;
  localparam int flag_bit      = 0;
  localparam int generate_bit  = 0;
  localparam int addr_lsb      = 2;
  localparam int addr_msb      = 7;

  localparam logic [15:0] reg_reset  = 16'h0000;
  localparam logic [15:0] count_one  = 16'h0001;
  localparam logic [31:0] read_zero  = 32'h0000_0000;

  // Trigger source encodings
  localparam logic [2:0] trig_on_reset  = 3'h0;
  localparam logic [2:0] trig_on_start  = 3'h1;
  localparam logic [2:0] trig_on_update = 3'h2;

  // Wishbone request carrier
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_s;

  // Counter events passed between units
  typedef struct packed {
    logic overflow;
    logic sw_update;
    logic start;
  } tick_events_s;

endpackage : timer_pkg
`default_nettype wire

//--- design/clock_divider.sv
// Prescaler with update-loaded shadow producing the counter tick
`timescale 1ns/1ps
`default_nettype none
module clock_divider (
  input  wire logic        clock,         // Timer clock
  input  wire logic        srst,          // Synchronous reset
  input  wire logic        run,           // Counter run bit
  input  wire logic        clear,         // Software update clear
  input  wire logic        load_shadow,   // Update event
  input  wire logic [15:0] divide_value,  // Preload divide value
  output logic             tick           // One counter clock pulse
);

  logic [15:0] shadow;
  logic [15:0] prescale_count;

  // Shadow copy only at update events
  always_ff @(posedge clock)
  begin
    if (srst)
      shadow <= timer_pkg::reg_reset;
    else if (load_shadow)
      shadow <= divide_value;
  end

  // Divide by shadow plus one
  always_ff @(posedge clock)
  begin
    if (srst || clear)
      prescale_count <= timer_pkg::reg_reset;
    else if (run)
    begin
      if (prescale_count >= shadow)
        prescale_count <= timer_pkg::reg_reset;
      else
        prescale_count <= prescale_count + timer_pkg::count_one;
    end
  end

  assign tick = run && !clear && (prescale_count >= shadow);

endmodule : clock_divider
`default_nettype wire

//--- design/trigger_select.sv
// Master trigger source selection
`timescale 1ns/1ps
`default_nettype none
module trigger_select (
  input  wire logic       clock,     // Timer clock
  input  wire logic       srst,      // Synchronous reset
  input  wire logic [2:0] select,    // Trigger source select
  input  wire logic       reset_ev,  // Counter reset event
  input  wire logic       start_ev,  // Counter start event
  input  wire logic       update_ev, // Update event
  output logic            pulse      // Registered trigger pulse
);

  // Pick the chosen event, others give nothing
  always_ff @(posedge clock)
  begin
    if (srst)
      pulse <= 1'b0;
    else
    begin
      unique case (select)
        timer_pkg::trig_on_reset:  pulse <= reset_ev;
        timer_pkg::trig_on_start:  pulse <= start_ev;
        timer_pkg::trig_on_update: pulse <= update_ev;
        default:                   pulse <= 1'b0;
      endcase
    end
  end

endmodule : trigger_select
`default_nettype wire

//--- design/basic_upcount_timer_regs.sv
// Basic up-counting timer with Wishbone register file
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module basic_upcount_timer_regs (
  input  wire logic        clock,              // 50 MHz timer clock
  input  wire logic        srst,               // Synchronous reset, high
  input  wire logic        wb_cyc_i,           // Bus cycle
  input  wire logic        wb_stb_i,           // Bus strobe
  input  wire logic        wb_we_i,            // Write enable
  input  wire logic [3:0]  wb_sel_i,           // Byte lane selects
  input  wire logic [7:0]  wb_adr_i,           // Byte address
  input  wire logic [31:0] wb_dat_i,           // Write data
  output logic      [31:0] wb_dat_o,           // Read data
  output logic             wb_ack_o,           // Acknowledge
  output logic             master_trigger_out, // Trigger to slave timers
  output logic             update_irq,         // Update interrupt
  output logic             update_dma_req      // Update DMA request pulse
);

  // ****************************************************************************
  // Declarations
  // ****************************************************************************
  timer_pkg::wb_req_s      req;
  timer_pkg::tick_events_s ev;
  logic [15:0] run_control;
  logic [15:0] trigger_out_control;
  logic [15:0] update_request_enable;
  logic        update_flag;
  logic [15:0] live_count;
  logic [15:0] clock_divide_setting;
  logic [15:0] reload_limit_value;
  logic        software_update_generate;
  logic        counter_run;
  logic        update_suppress;
  logic        update_source_select;
  logic        one_shot_select;
  logic        access;
  logic        wr;
  logic        update_event;
  logic        request_event;
  logic        run_rise;
  logic        count_write;
  logic        tick;
  logic        irq_trigger;
  logic [15:0] next_count;

  // Bundle bus inputs
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // Merge byte lanes of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = data[7:0];
    if (sel[1])
      res[15:8] = data[15:8];
    return res;
  endfunction : merge16

  // Address hit on a given offset, for reads and writes
  function automatic logic hit(input timer_pkg::wb_req_s r, input logic [7:0] off);
    return r.adr[timer_pkg::addr_msb:timer_pkg::addr_lsb] ==
           off[timer_pkg::addr_msb:timer_pkg::addr_lsb];
  endfunction : hit

  // ****************************************************************************
  // Bus handshake
  // ****************************************************************************
  assign access = req.cyc && req.stb && !wb_ack_o;
  assign wr     = access && req.we;

  // One-cycle answer, dropped the cycle after
  always_ff @(posedge clock)
  begin
    if (srst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  // ****************************************************************************
  // Control fields
  // ****************************************************************************
  assign counter_run          = run_control[timer_pkg::run_bit];
  assign update_suppress      = run_control[timer_pkg::suppress_bit];
  assign update_source_select = run_control[timer_pkg::source_bit];
  assign one_shot_select      = run_control[timer_pkg::one_shot_bit];

  // Run control register; one-shot clears run at update
  always_ff @(posedge clock)
  begin
    if (srst)
      run_control <= timer_pkg::reg_reset;
    else if (wr && hit(req, timer_pkg::run_control_off))
      run_control <= merge16(run_control, req.dat, req.sel);
    else if (update_event && one_shot_select)
      run_control[timer_pkg::run_bit] <= 1'b0;
  end

  // Trigger source field, only bits 6 to 4 held
  always_ff @(posedge clock)
  begin
    if (srst)
      trigger_out_control <= timer_pkg::reg_reset;
    else if (wr && hit(req, timer_pkg::trigger_out_off) && req.sel[0])
      trigger_out_control[timer_pkg::trig_msb:timer_pkg::trig_lsb] <=
        req.dat[timer_pkg::trig_msb:timer_pkg::trig_lsb];
  end

  // Interrupt and DMA enable bits
  always_ff @(posedge clock)
  begin
    if (srst)
      update_request_enable <= timer_pkg::reg_reset;
    else if (wr && hit(req, timer_pkg::request_enable_off))
    begin
      if (req.sel[0])
        update_request_enable[timer_pkg::irq_en_bit] <= req.dat[timer_pkg::irq_en_bit];
      if (req.sel[1])
        update_request_enable[timer_pkg::dma_en_bit] <= req.dat[timer_pkg::dma_en_bit];
    end
  end

  // Divide value and reload limit
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      clock_divide_setting <= timer_pkg::reg_reset;
      reload_limit_value   <= timer_pkg::reg_reset;
    end
    else if (wr && hit(req, timer_pkg::divide_value_off))
      clock_divide_setting <= merge16(clock_divide_setting, req.dat, req.sel);
    else if (wr && hit(req, timer_pkg::reload_limit_off))
      reload_limit_value <= merge16(reload_limit_value, req.dat, req.sel);
  end

  // Software update request, self-clearing after one cycle
  always_ff @(posedge clock)
  begin
    if (srst)
      software_update_generate <= 1'b0;
    else
      software_update_generate <= wr && hit(req, timer_pkg::event_request_off) &&
                                  req.sel[0] && req.dat[timer_pkg::generate_bit];
  end

  // ****************************************************************************
  // Counter core
  // ****************************************************************************
  clock_divider u_divider (
    .clock        (clock),
    .srst         (srst),
    .run          (counter_run),
    .clear        (software_update_generate),
    .load_shadow  (update_event),
    .divide_value (clock_divide_setting),
    .tick         (tick)
  );

  assign ev.overflow  = tick && (live_count >= reload_limit_value);
  assign ev.sw_update = software_update_generate;
  assign ev.start     = run_rise;

  // Update event unless suppressed
  assign update_event  = !update_suppress && (ev.overflow || ev.sw_update);
  // Interrupt and DMA sources narrowed by source select
  assign request_event = !update_suppress &&
                         (ev.overflow || (ev.sw_update && !update_source_select));
  assign count_write   = wr && hit(req, timer_pkg::count_value_off);

  // Next counter value
  always_comb
  begin
    next_count = live_count;
    if (count_write)
      next_count = merge16(live_count, req.dat, req.sel);
    else if (ev.sw_update)
      next_count = timer_pkg::reg_reset;
    else if (ev.overflow)
      next_count = timer_pkg::reg_reset;
    else if (tick)
      next_count = live_count + timer_pkg::count_one;
  end

  // Counter register; one-shot wrap also clears it
  always_ff @(posedge clock)
  begin
    if (srst)
      live_count <= timer_pkg::reg_reset;
    else
      live_count <= next_count;
  end

  // Rising edge of run bit as start event
  logic run_prev;
  always_ff @(posedge clock)
  begin
    if (srst)
      run_prev <= 1'b0;
    else
      run_prev <= counter_run;
  end
  assign run_rise = counter_run && !run_prev;

  // Update flag, set wins over software clear
  always_ff @(posedge clock)
  begin
    if (srst)
      update_flag <= 1'b0;
    else if (request_event)
      update_flag <= 1'b1;
    else if (wr && hit(req, timer_pkg::flag_status_off) && req.sel[0] &&
             !req.dat[timer_pkg::flag_bit])
      update_flag <= 1'b0;
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  assign irq_trigger = (update_flag || request_event) &&
                       update_request_enable[timer_pkg::irq_en_bit];

  // Interrupt level follows flag and enable
  always_ff @(posedge clock)
  begin
    if (srst)
      update_irq <= 1'b0;
    else if (wr && hit(req, timer_pkg::request_enable_off) && req.sel[0])
      update_irq <= (update_flag || request_event) && req.dat[timer_pkg::irq_en_bit];
    else if (wr && hit(req, timer_pkg::flag_status_off) && req.sel[0] &&
             !req.dat[timer_pkg::flag_bit] && !request_event)
      update_irq <= 1'b0;
    else
      update_irq <= irq_trigger;
  end

  // DMA request pulse per update
  always_ff @(posedge clock)
  begin
    if (srst)
      update_dma_req <= 1'b0;
    else
      update_dma_req <= request_event &&
                        update_request_enable[timer_pkg::dma_en_bit];
  end

  trigger_select u_trigger (
    .clock     (clock),
    .srst      (srst),
    .select    (trigger_out_control[timer_pkg::trig_msb:timer_pkg::trig_lsb]),
    .reset_ev  (ev.sw_update),
    .start_ev  (ev.start),
    .update_ev (update_event),
    .pulse     (master_trigger_out)
  );

  // Read mux; unmapped and write-only read zero
  always_ff @(posedge clock)
  begin
    if (srst)
      wb_dat_o <= timer_pkg::read_zero;
    else if (access && !req.we)
    begin
      wb_dat_o <= timer_pkg::read_zero;
      if (hit(req, timer_pkg::run_control_off))
        wb_dat_o[15:0] <= run_control;
      else if (hit(req, timer_pkg::trigger_out_off))
        wb_dat_o[15:0] <= trigger_out_control;
      else if (hit(req, timer_pkg::request_enable_off))
        wb_dat_o[15:0] <= update_request_enable;
      else if (hit(req, timer_pkg::flag_status_off))
        wb_dat_o[timer_pkg::flag_bit] <= update_flag;
      else if (hit(req, timer_pkg::count_value_off))
        wb_dat_o[15:0] <= live_count;
      else if (hit(req, timer_pkg::divide_value_off))
        wb_dat_o[15:0] <= clock_divide_setting;
      else if (hit(req, timer_pkg::reload_limit_off))
        wb_dat_o[15:0] <= reload_limit_value;
    end
  end

endmodule : basic_upcount_timer_regs
`default_nettype wire

//--- bench/timer_monitor.sv
// Checker of bus, interrupt, request and trigger behaviour at the timer ports
`timescale 1ns/1ps
`default_nettype none
module timer_monitor (
  input wire logic        clock,              // Timer clock
  input wire logic        srst,               // Synchronous reset
  input wire logic        wb_cyc_i,           // Bus cycle
  input wire logic        wb_stb_i,           // Bus strobe
  input wire logic        wb_we_i,            // Write enable
  input wire logic [3:0]  wb_sel_i,           // Byte lanes
  input wire logic [7:0]  wb_adr_i,           // Byte address
  input wire logic [31:0] wb_dat_i,           // Write data
  input wire logic [31:0] wb_dat_o,           // Read data
  input wire logic        wb_ack_o,           // Acknowledge
  input wire logic        master_trigger_out, // Trigger output
  input wire logic        update_irq,         // Update interrupt
  input wire logic        update_dma_req      // Update request
);
  logic       wr_take; // Write accepted now
  logic [1:0] en_q;    // Request and interrupt enables
  logic [2:0] trig_q;  // Trigger select copy
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ********
  // Helper copies of written fields
  // ********
  assign wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  // Enable bits follow accepted writes
  always_ff @(posedge clock)
  begin
    if (srst)
      en_q <= 2'h0;
    else if (wr_take && wb_adr_i[7:2] == 6'h03)
      en_q <= {wb_sel_i[1] ? wb_dat_i[8] : en_q[1], wb_sel_i[0] ? wb_dat_i[0] : en_q[0]};
  end
  // Trigger select follows accepted writes
  always_ff @(posedge clock)
  begin
    if (srst)
      trig_q <= 3'h0;
    else if (wr_take && wb_adr_i[7:2] == 6'h01 && wb_sel_i[0])
      trig_q <= wb_dat_i[6:4];
  end
  // ********
  // Assertions
  // ********
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_WO_READ: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h14 |-> wb_dat_o == 32'h0)
    else $error("event request register reads nonzero");
  AST_IRQ_MASK: assert property (!en_q[0] && !$past(en_q[0]) && !$past(en_q[0], 2) |-> !update_irq)
    else $error("interrupt while disabled");
  AST_DMA_MASK: assert property (!en_q[1] && !$past(en_q[1]) && !$past(en_q[1], 2) |-> !update_dma_req)
    else $error("request while disabled");
  AST_TRIG_UNUSED: assert property (trig_q > 3'h2 && $stable(trig_q) && trig_q == $past(trig_q, 2)
    |-> !master_trigger_out)
    else $error("trigger under unused select");
  AST_IRQ_HOLD: assert property (update_irq && en_q[0] && !wb_cyc_i && !$past(wb_cyc_i)
    && !$past(wb_cyc_i, 2) |=> update_irq)
    else $error("interrupt dropped without clear");
  // Main scenarios reached
  COV_DMA: cover property (update_dma_req);
  COV_TRIG: cover property (master_trigger_out);
  COV_IRQ: cover property (update_irq);
  COV_READ: cover property (wb_ack_o && !wb_we_i);
endmodule : timer_monitor
`default_nettype wire

//--- bench/trigger_sink.sv
// Slave-timer side model counting trigger and update request pulses
`timescale 1ns/1ps
`default_nettype none
module trigger_sink (
  input  wire logic        clock,      // Timer clock
  input  wire logic        srst,       // Synchronous reset
  input  wire logic        trig_in,    // Master trigger input
  input  wire logic        dma_in,     // Update request input
  output logic      [15:0] trig_count, // Trigger pulses seen
  output logic      [15:0] dma_count   // Requests served
);
  // One count per high cycle of each input
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      trig_count <= 16'h0000;
      dma_count <= 16'h0000;
    end
    else
    begin
      trig_count <= trig_count + 16'(trig_in);
      dma_count <= dma_count + 16'(dma_in);
    end
  end
endmodule : trigger_sink
`default_nettype wire

//--- bench/tb.sv
// Self-checking testbench of the basic timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               clock;
  logic               srst;
  timer_pkg::wb_req_s req;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o, master_trigger_out, update_irq, update_dma_req;
  logic [15:0]        trig_count, dma_count, d, tc, dc;
  logic [7:0]         offs [9] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h24, 8'h28, 8'h2C, 8'h30};
  int                 num_errors = 0, tests_run = 0, cyc_cnt = 0;
  int                 t0, t1, t2, dv, lim, per, per2;
  basic_upcount_timer_regs uut (
    .clock(clock), .srst(srst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .master_trigger_out(master_trigger_out),
    .update_irq(update_irq), .update_dma_req(update_dma_req)
  );
  trigger_sink sink (
    .clock(clock), .srst(srst), .trig_in(master_trigger_out), .dma_in(update_dma_req),
    .trig_count(trig_count), .dma_count(dma_count)
  );
  // Clock and cycle counter
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) cyc_cnt <= cyc_cnt + 1;
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Cycles between two overflows for a divide value and a reload limit
  function automatic int period(input int div, input int limit);
    return (div + 1) * (limit + 1);
  endfunction : period
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] s, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
    @(posedge clock);
    while (wb_ack_o !== 1'b1)
      @(posedge clock);
    q = wb_dat_o;
    req <= '0;
    @(posedge clock);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, 4'h3, a, {16'h0000, d}, q);  // Half-word write
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    wb(1'b0, 4'hF, a, 32'h0, q);
    chk($sformatf("reg %h", a), q, {16'h0000, e});
  endtask : rdc
  task automatic wait_dma(output int t);
    int n;
    n = 0;
    @(posedge clock);
    while (update_dma_req !== 1'b1 && n < 4000)
    begin
      @(posedge clock);
      n++;
    end
    chk("dma wait", 32'(n < 4000), 32'h1);
    t = cyc_cnt;
  endtask : wait_dma
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // ********
  // Main sequence
  // ********
  initial
  begin
    void'($urandom(32'h3C49));
    req = '0;
    srst = 1'b1;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    foreach (offs[i]) rdc(offs[i], 16'h0000);
    d = 16'($urandom);
    wr(8'h24, d);
    rdc(8'h24, d);
    wr(8'h2C, ~d);
    rdc(8'h2C, ~d);
    wr(8'h30, d);
    rdc(8'h30, 16'h0000);
    dv = $urandom_range(3, 1);
    lim = $urandom_range(9, 4);
    per = period(dv, lim);
    per2 = period(dv + 2, lim);
    wr(8'h28, 16'(dv));
    wr(8'h2C, 16'(lim));
    wr(8'h0C, 16'h0101);
    rdc(8'h0C, 16'h0101);
    wr(8'h04, 16'h0020);
    rdc(8'h04, 16'h0020);
    tc = trig_count;
    dc = dma_count;
    wr(8'h14, 16'h0001);
    wr(8'h00, 16'h0001);
    wait_dma(t0);
    wr(8'h28, 16'(dv + 2));
    wait_dma(t1);
    wait_dma(t2);
    chk("old period", t1 - t0, per);
    chk("new period", t2 - t1, per2);
    @(posedge clock);
    chk("update trigger", 32'(trig_count - tc), 32'h4);
    chk("update dma", 32'(dma_count - dc), 32'h4);
    chk("irq set", 32'(update_irq), 32'h1);
    wr(8'h00, 16'h0000);
    rdc(8'h10, 16'h0001);
    wr(8'h10, 16'h0001);
    rdc(8'h10, 16'h0001);
    wr(8'h10, 16'h0000);
    rdc(8'h10, 16'h0000);
    chk("irq clear", 32'(update_irq), 32'h0);
    wr(8'h0C, 16'h0000);
    dc = dma_count;
    wr(8'h14, 16'h0001);
    repeat (6) @(posedge clock);
    chk("irq masked", 32'(update_irq), 32'h0);
    chk("dma masked", 32'(dma_count - dc), 32'h0);
    wr(8'h0C, 16'h0001);
    repeat (3) @(posedge clock);
    chk("irq unmasked", 32'(update_irq), 32'h1);
    wr(8'h10, 16'h0000);
    wr(8'h04, 16'h0000);
    wr(8'h24, 16'h0055);
    tc = trig_count;
    wr(8'h14, 16'h0001);
    repeat (6) @(posedge clock);
    chk("reset trigger", 32'(trig_count - tc), 32'h1);
    rdc(8'h24, 16'h0000);
    rdc(8'h14, 16'h0000);
    wr(8'h04, 16'h0010);
    tc = trig_count;
    wr(8'h00, 16'h0001);
    repeat (6) @(posedge clock);
    chk("start trigger", 32'(trig_count - tc), 32'h1);
    for (int s = 3; s < 8; s++)
    begin
      wr(8'h04, 16'(s << 4));
      tc = trig_count;
      repeat (2 * per2) @(posedge clock);
      chk("unused select", 32'(trig_count - tc), 32'h0);
    end
    wr(8'h00, 16'h0003);
    wr(8'h0C, 16'h0101);
    wr(8'h10, 16'h0000);
    dc = dma_count;
    repeat (3 * per2) @(posedge clock);
    chk("suppressed", 32'(dma_count - dc), 32'h0);
    rdc(8'h10, 16'h0000);
    wr(8'h00, 16'h0004);
    wr(8'h24, 16'h0033);
    wr(8'h14, 16'h0001);
    repeat (6) @(posedge clock);
    chk("overflow only", 32'(dma_count - dc), 32'h0);
    rdc(8'h10, 16'h0000);
    rdc(8'h24, 16'h0000);
    wr(8'h00, 16'h000D);
    wait_dma(t0);
    repeat (4) @(posedge clock);
    rdc(8'h00, 16'h000C);
    rdc(8'h24, 16'h0000);
    rdc(8'h10, 16'h0001);
    give_verdict();
  end
  // Watchdog against a hung run
  initial
  begin
    repeat (30000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule : tb
bind basic_upcount_timer_regs timer_monitor mon (
  .clock(clock), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .master_trigger_out(master_trigger_out), .update_irq(update_irq),
  .update_dma_req(update_dma_req)
);
`default_nettype wire
